// *** hdl/passive_ctrl_pkg.sv ***
// Package of constants and types for the passive-mode gate control
// Summary of operation
// - Pull-downs on when enable low or logic-off, except on driven brake switches
// - Normal active: pull-downs off, hold current on
// - Driver-disabling fault or fail-safe: pull-downs on
// - Passive bit with idle bridges, not in sleep/off: power down
// - Passive when requested-idle, sleep, or logic-off
// - Passive: only four brake switches driven
// - Selector 00: brake switches off
// - Selector 01: brake switches on statically
// - Selector 10: brake on overvoltage, flag pin low
// - Selector 11: brake on overvoltage and input high
// - Sleep battery dip latches selector 10 behaviour
// - Passive bit clear: selector only in sleep/off
package passive_ctrl_pkg;
    // Number of half-bridges and brake switches
    localparam int NUM_BRIDGES = 8;
    localparam int NUM_BRAKE = 4;
    // Half-bridge mode field codes that count as idle
    localparam logic [1:0] HB_MODE_OFF = 2'h0;
    localparam logic [1:0] HB_MODE_IDLE = 2'h3;
    // Passive brake selector encoding
    localparam logic [1:0] SEL_OFF = 2'h0;
    localparam logic [1:0] SEL_STATIC = 2'h1;
    localparam logic [1:0] SEL_OV = 2'h2;
    localparam logic [1:0] SEL_OV_GATED = 2'h3;
    // Reset values
    localparam logic DIP_LATCH_RESET = 1'b0;
    localparam logic PULLDOWN_RESET = 1'b1;
    // Operating state of the bridge driver
    typedef enum logic [1:0] {
        ST_ACTIVE = 2'b00,
        ST_PASSIVE = 2'b01,
        ST_FAULT = 2'b11
    } drive_state_type;
endpackage : passive_ctrl_pkg

// *** hdl/sync_two_ff.sv ***
// Two flip-flop synchroniser for one level input
`timescale 1ns/1ns
module sync_two_ff (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic async_i,
    output logic sync_o
);
    logic meta_reg; // First stage, read only by second stage
    logic meta_next;
    logic sync_reg; // Second stage
    logic sync_next;

    // Next values of the two stages
    always_comb begin
        meta_next = async_i;
        sync_next = meta_reg;
    end

    // Register both stages
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign sync_o = sync_reg;
endmodule : sync_two_ff

// *** hdl/gate_driver_passive_mode_control.sv ***
// Top module deciding gate pull-downs and passive brake switch control
`timescale 1ns/1ns
module gate_driver_passive_mode_control #(
    parameter int NB = passive_ctrl_pkg::NUM_BRIDGES, // Half-bridge count
    parameter int NL = passive_ctrl_pkg::NUM_BRAKE // Brake switch count
) (
    input wire logic core_clk_i, // System clock
    input wire logic rst_i, // Asynchronous reset, active high
    input wire logic enable_pin_i, // Enable pin, low means sleep
    input wire logic logic_supply_off_i, // Logic supply below off level
    input wire logic battery_sleep_low_i, // Battery below sleep threshold
    input wire logic battery_overvoltage_i, // Battery above passive overvoltage threshold
    input wire logic brake_gate_input_i, // First PWM pin level
    input wire logic fault_disable_i, // Charge pump, supply or thermal fault
    input wire logic fail_safe_i, // Fail-safe mode
    input wire logic bridge_passive_request_i, // Passive-mode bit
    input wire logic [2*NB-1:0] half_bridge_drive_mode_i, // Mode fields, two bits each
    input wire logic [1:0] passive_brake_select_i, // Passive brake selector
    output logic high_pulldown_en_o, // Pull-downs on high-side gates
    output logic low_pulldown_en_o, // Pull-downs on other low-side gates
    output logic gate_hold_current_en_o, // Active hold discharge current
    output logic driver_power_down_o, // Gate driver powered down
    output logic bridge_passive_o, // Bridge driver in passive mode
    output logic [NL-1:0] low_switch_on_o, // Brake switches one to four
    output logic [NL-1:0] low_switch_pulldown_en_o, // Pull-downs on brake switches
    output logic open_drain_flag_pin_o, // Flag pin output level (always low)
    output logic open_drain_flag_pin_oe_o, // Flag pin pull-down enable
    output logic dip_latched_o // Forced overvoltage brake latched
);
    import passive_ctrl_pkg::*;

    // Synchronised pin-side inputs, two edges behind their pins
    logic en_s; // Enable pin, low means sleep
    logic vdd_off_s; // Logic supply below its off level
    logic vs_low_s; // Battery below sleep threshold
    logic vs_ov_s; // Battery above passive overvoltage threshold
    logic pwm_s; // Brake gate input level

    // Every pin-side level passes two flip-flops before any logic reads it
    // Trade-off: three edges from pin to output, but no metastable reads
    sync_two_ff u_sync_en (.core_clk_i(core_clk_i), .rst_i(rst_i), .async_i(enable_pin_i), .sync_o(en_s));
    sync_two_ff u_sync_vdd (.core_clk_i(core_clk_i), .rst_i(rst_i), .async_i(logic_supply_off_i),
                            .sync_o(vdd_off_s));
    sync_two_ff u_sync_low (.core_clk_i(core_clk_i), .rst_i(rst_i), .async_i(battery_sleep_low_i),
                            .sync_o(vs_low_s));
    sync_two_ff u_sync_ov (.core_clk_i(core_clk_i), .rst_i(rst_i), .async_i(battery_overvoltage_i),
                           .sync_o(vs_ov_s));
    sync_two_ff u_sync_pwm (.core_clk_i(core_clk_i), .rst_i(rst_i), .async_i(brake_gate_input_i),
                            .sync_o(pwm_s));

    // Registered state and outputs
    drive_state_type state_reg; // Operating state of the bridge driver
    drive_state_type state_next; // Next operating state
    logic dip_reg; // Battery dip latch
    logic dip_next; // Next value of the dip latch
    logic hpd_reg; // High-side gate pull-downs
    logic hpd_next; // Next high-side pull-down enable
    logic lpd_reg; // Pull-downs on the other low-side gates
    logic lpd_next; // Next low-side pull-down enable
    logic hold_reg; // Active hold discharge current
    logic hold_next; // Next hold current enable
    logic pdn_reg; // Gate driver power down
    logic pdn_next; // Next power down
    logic pass_reg; // Passive mode flag
    logic pass_next; // Next passive mode flag
    logic [NL-1:0] ls_reg; // Brake switch gate commands
    logic [NL-1:0] ls_next; // Next brake switch commands
    logic [NL-1:0] lspd_reg; // Brake switch pull-downs
    logic [NL-1:0] lspd_next; // Next brake switch pull-downs
    logic od_reg; // Flag pin open drain enable
    logic od_next; // Next open drain enable

    // Decoded conditions
    logic sleep_like; // Enable low or logic supply off
    logic bridges_idle; // Every mode field idle
    logic [1:0] eff_sel; // Selector after dip override
    logic brake_on;

    // Bridge idle detection over all mode fields
    always_comb begin
        bridges_idle = 1'b1;
        for (int i = 0; i < NB; i++) begin
            // Codes 00 and 11 leave a bridge idle; anything else drives it
            if (half_bridge_drive_mode_i[2*i +: 2] != HB_MODE_OFF &&
                half_bridge_drive_mode_i[2*i +: 2] != HB_MODE_IDLE) begin
                bridges_idle = 1'b0;
            end
        end
    end

    // Sleep or logic supply off, seen through the synchronisers
    assign sleep_like = !en_s || vdd_off_s;

    // Battery dip latch: sets while sleep-like and the battery dips
    always_comb begin
        // Hold by default; nothing but reset clears the latch
        dip_next = dip_reg;
        if (sleep_like && vs_low_s) begin
            // Dip seen: keep the overvoltage brake even after recovery
            dip_next = 1'b1;
        end
    end

    // Register the dip latch; only reset clears it
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            // Power-on state: no dip recorded
            dip_reg <= DIP_LATCH_RESET;
        end else begin
            dip_reg <= dip_next;
        end
    end

    // Next state and output values
    always_comb begin
        // Dip override applies only in sleep-like state
        if (sleep_like && (dip_reg || vs_low_s)) begin
            // A present dip counts at once, before the latch has caught it
            eff_sel = SEL_OV;
        end else begin
            // Host selector as given
            eff_sel = passive_brake_select_i;
        end
        // Passive decision; selector acts only if passive
        if (sleep_like || (bridge_passive_request_i && bridges_idle)) begin
            // Passive wins over faults: every pull-down is on there anyway, except on driven brake switches
            state_next = ST_PASSIVE;
        end else if (fault_disable_i || fail_safe_i) begin
            // Gate drivers disabled, pull-downs back on
            state_next = ST_FAULT;
        end else begin
            // Normal drive with hold current
            state_next = ST_ACTIVE;
        end
        // Brake switch decode
        // Overvoltage modes use the synchronised battery comparator
        case (eff_sel)
            SEL_OFF: brake_on = 1'b0;
            SEL_STATIC: brake_on = 1'b1;
            SEL_OV: brake_on = vs_ov_s;
            SEL_OV_GATED: brake_on = vs_ov_s && pwm_s;
            default: brake_on = 1'b0;
        endcase
        // Defaults: everything off and pulled down
        hpd_next = 1'b1;
        lpd_next = 1'b1;
        hold_next = 1'b0;
        pdn_next = 1'b0;
        pass_next = 1'b0;
        ls_next = '0;
        lspd_next = '1;
        od_next = 1'b0;
        case (state_next)
            ST_ACTIVE: begin
                // Active hold current replaces pull-downs
                hpd_next = 1'b0;
                lpd_next = 1'b0;
                // Brake switch pull-downs off too; hold current keeps them off
                lspd_next = '0;
                hold_next = 1'b1;
            end
            ST_PASSIVE: begin
                // Pull-downs on except driven brake switches
                pass_next = 1'b1;
                pdn_next = !sleep_like;
                ls_next = {NL{brake_on}};
                // Brake switch pull-downs follow the brake, never fight it
                lspd_next = {NL{!brake_on}};
                od_next = eff_sel[1];
            end
            ST_FAULT: begin
                // All gates pulled down, brakes off, no hold current
                hpd_next = 1'b1;
            end
            default: begin
                // Unused code: fall back to the safe defaults
                hpd_next = 1'b1;
            end
        endcase
    end

    // Register state and outputs
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            // Reset: every pull-down on, brakes off, hold current off
            state_reg <= ST_PASSIVE;
            hpd_reg <= PULLDOWN_RESET;
            lpd_reg <= PULLDOWN_RESET;
            hold_reg <= 1'b0;
            pdn_reg <= 1'b0;
            pass_reg <= 1'b0;
            ls_reg <= '0;
            lspd_reg <= '1;
            od_reg <= 1'b0;
        end else begin
            // Plain update on every edge
            state_reg <= state_next;
            hpd_reg <= hpd_next;
            lpd_reg <= lpd_next;
            hold_reg <= hold_next;
            pdn_reg <= pdn_next;
            pass_reg <= pass_next;
            ls_reg <= ls_next;
            lspd_reg <= lspd_next;
            od_reg <= od_next;
        end
    end

    // Outputs straight from flip-flops
    assign high_pulldown_en_o = hpd_reg;
    assign low_pulldown_en_o = lpd_reg;
    assign gate_hold_current_en_o = hold_reg;
    assign driver_power_down_o = pdn_reg;
    assign bridge_passive_o = pass_reg;
    assign low_switch_on_o = ls_reg;
    assign low_switch_pulldown_en_o = lspd_reg;
    // Open drain only ever pulls low; the enable says when
    assign open_drain_flag_pin_o = 1'b0;
    assign open_drain_flag_pin_oe_o = od_reg;
    assign dip_latched_o = dip_reg;
endmodule : gate_driver_passive_mode_control

// *** tb/brake_gate_model.sv ***
// External brake switch gates and the pulled-up flag pin wire
`timescale 1ns/1ns
module brake_gate_model (
    input wire logic [3:0] gate_drive_i,
    input wire logic [3:0] gate_pulldown_i,
    input wire logic flag_oe_i,
    input wire logic flag_level_i,
    output logic [3:0] mosfet_on_o,
    output logic flag_wire_o
);
    // A gate conducts only when driven and not pulled down
    assign mosfet_on_o = gate_drive_i & ~gate_pulldown_i;
    // Board pull-up holds the line high unless the open drain pulls it
    assign flag_wire_o = flag_oe_i ? flag_level_i : 1'h1;
endmodule : brake_gate_model

// *** tb/gate_driver_passive_mode_control_props.sv ***
// Port checker for the passive-mode gate control
`timescale 1ns/1ns
module passive_ctrl_checker #(
    parameter int NB = passive_ctrl_pkg::NUM_BRIDGES,
    parameter int NL = passive_ctrl_pkg::NUM_BRAKE
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic enable_pin_i,
    input wire logic fault_disable_i,
    input wire logic fail_safe_i,
    input wire logic bridge_passive_request_i,
    input wire logic [1:0] passive_brake_select_i,
    input wire logic high_pulldown_en_o,
    input wire logic low_pulldown_en_o,
    input wire logic gate_hold_current_en_o,
    input wire logic driver_power_down_o,
    input wire logic bridge_passive_o,
    input wire logic [NL-1:0] low_switch_on_o,
    input wire logic [NL-1:0] low_switch_pulldown_en_o,
    input wire logic open_drain_flag_pin_o,
    input wire logic open_drain_flag_pin_oe_o,
    input wire logic dip_latched_o
);
    import passive_ctrl_pkg::*;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    // Enable pin low long enough to pass the synchroniser
    sequence sleep_held; !enable_pin_i [*4]; endsequence
    sequence sel_then_passive(logic [1:0] s); passive_brake_select_i == s ##1 bridge_passive_o && !dip_latched_o;
    endsequence
    AST_SLEEP_PULLDOWN: assert property (
        sleep_held |-> bridge_passive_o && high_pulldown_en_o && low_pulldown_en_o)
        else $error("sleep without pulldowns");
    AST_ACTIVE_HOLD: assert property (gate_hold_current_en_o |-> !high_pulldown_en_o && !bridge_passive_o)
        else $error("hold current with pulldowns");
    AST_FAULT_PULLDOWN: assert property (
        (fault_disable_i || fail_safe_i) |=> bridge_passive_o || (high_pulldown_en_o && !gate_hold_current_en_o))
        else $error("fault left gates active");
    AST_POWER_DOWN: assert property (
        driver_power_down_o |-> bridge_passive_o && high_pulldown_en_o && $past(bridge_passive_request_i))
        else $error("power down without request");
    AST_BRAKE_PULLDOWN: assert property (bridge_passive_o |-> low_switch_pulldown_en_o == ~low_switch_on_o)
        else $error("brake pulldown mismatch");
    AST_SELECT_OFF: assert property (sel_then_passive(SEL_OFF) |-> low_switch_on_o == '0)
        else $error("brake on with selector off");
    AST_SELECT_STATIC: assert property (sel_then_passive(SEL_STATIC) |-> low_switch_on_o == {NL{1'h1}})
        else $error("static brake not on");
    AST_FLAG_PIN: assert property (
        passive_brake_select_i[1] ##1 bridge_passive_o |-> open_drain_flag_pin_oe_o && !open_drain_flag_pin_o)
        else $error("flag pin not pulled low");
    AST_ACTIVE_NO_BRAKE: assert property (!bridge_passive_o |-> low_switch_on_o == '0)
        else $error("brake on while not passive");
    AST_DIP_KEEP: assert property (dip_latched_o |=> dip_latched_o)
        else $error("dip latch dropped");
endmodule : passive_ctrl_checker
bind gate_driver_passive_mode_control passive_ctrl_checker #(.NB(NB), .NL(NL)) checker_u (.core_clk_i, .rst_i,
    .enable_pin_i, .fault_disable_i, .fail_safe_i, .bridge_passive_request_i, .passive_brake_select_i,
    .high_pulldown_en_o, .low_pulldown_en_o, .gate_hold_current_en_o, .driver_power_down_o, .bridge_passive_o,
    .low_switch_on_o, .low_switch_pulldown_en_o, .open_drain_flag_pin_o, .open_drain_flag_pin_oe_o, .dip_latched_o);

// *** tb/gate_driver_passive_mode_control_test.sv ***
// Testbench for the passive-mode gate control
`timescale 1ns/1ns
module gate_driver_passive_mode_control_test;
    import passive_ctrl_pkg::*;
    logic core_clk_i = 1'h0, rst_i = 1'h1, en = 1'h0, lsoff = 1'h0, slp = 1'h0, ov = 1'h0, pw = 1'h0;
    logic flt = 1'h0, fs = 1'h0, req = 1'h0, hpd, lpd, hold, pdn, pas, dip, fl, floe, flw;
    logic [15:0] modes = 16'h0000;
    logic [1:0] sel = 2'h0;
    logic [3:0] lson, lspd, mon;
    int fails = 0;
    int num_checks = 0;
    gate_driver_passive_mode_control dut_u (.core_clk_i, .rst_i, .enable_pin_i(en), .logic_supply_off_i(lsoff),
        .battery_sleep_low_i(slp), .battery_overvoltage_i(ov), .brake_gate_input_i(pw), .fault_disable_i(flt),
        .fail_safe_i(fs), .bridge_passive_request_i(req), .half_bridge_drive_mode_i(modes),
        .passive_brake_select_i(sel), .high_pulldown_en_o(hpd), .low_pulldown_en_o(lpd),
        .gate_hold_current_en_o(hold), .driver_power_down_o(pdn), .bridge_passive_o(pas), .low_switch_on_o(lson),
        .low_switch_pulldown_en_o(lspd), .open_drain_flag_pin_o(fl), .open_drain_flag_pin_oe_o(floe),
        .dip_latched_o(dip));
    brake_gate_model gates_u (.gate_drive_i(lson), .gate_pulldown_i(lspd), .flag_oe_i(floe), .flag_level_i(fl),
        .mosfet_on_o(mon), .flag_wire_o(flw));
    always #10 core_clk_i = ~core_clk_i;
    // Compare and count
    task automatic chk(input string nm, input logic [3:0] exp, input logic [3:0] act);
        num_checks++;
        if (act !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, exp, act);
        end
    endtask : chk
    // Three edges of latency plus one spare
    task automatic settle;
        repeat (4) @(posedge core_clk_i);
        #1;
    endtask : settle
    function automatic logic [3:0] brake(input logic [1:0] s, input logic v, input logic p);
        return (s == SEL_STATIC || (s[1] && v && (p || !s[0]))) ? 4'hF : 4'h0;
    endfunction : brake
    // Every selector with every overvoltage and input level
    task automatic sweep;
        for (int c = 0; c < 16; c++) begin
            @(posedge core_clk_i);
            {pw, ov, sel} <= c[3:0];
            settle;
            chk("brake", brake(c[1:0], c[2], c[3]), mon);
            chk("flag", {3'h0, ~c[1]}, {3'h0, flw});
        end
    endtask : sweep
    task automatic t_active;
        @(posedge core_clk_i);
        en <= 1'h1;
        settle;
        chk("active", 4'h8, {hold, hpd, lpd, pas});
        for (int f = 1; f < 4; f++) begin
            @(posedge core_clk_i);
            {fs, flt} <= f[1:0];
            settle;
            chk("fault", 4'h6, {hold, hpd, lpd, pas});
        end
        @(posedge core_clk_i);
        {fs, flt} <= 2'h0;
        $display("active test done");
    endtask : t_active
    task automatic t_request;
        @(posedge core_clk_i);
        req <= 1'h1;
        modes <= 16'h0400;
        settle;
        chk("busy bridge", 4'h0, {2'h0, pas, pdn});
        @(posedge core_clk_i);
        modes <= 16'hFFFF;
        settle;
        chk("idle bridges", 4'hF, {hpd, lpd, pas, pdn});
        sweep;
        $display("request test done");
    endtask : t_request
    task automatic t_sleep;
        @(posedge core_clk_i);
        req <= 1'h0;
        en <= 1'h0;
        settle;
        chk("sleep", 4'hE, {hpd, lpd, pas, pdn});
        sweep;
        @(posedge core_clk_i);
        en <= 1'h1;
        lsoff <= 1'h1;
        sel <= SEL_STATIC;
        settle;
        chk("logic off", 4'hF, mon);
        $display("sleep test done");
    endtask : t_sleep
    task automatic t_dip;
        @(posedge core_clk_i);
        {ov, slp, sel} <= {2'h1, SEL_OFF};
        settle;
        @(posedge core_clk_i);
        slp <= 1'h0;
        settle;
        chk("dip", 4'h1, {3'h0, dip});
        chk("dip flag", 4'h0, {3'h0, flw});
        @(posedge core_clk_i);
        ov <= 1'h1;
        settle;
        chk("dip brake", 4'hF, mon);
        @(posedge core_clk_i);
        lsoff <= 1'h0;
        settle;
        chk("dip kept", 4'h1, {3'h0, dip});
        chk("dip active", 4'h0, mon);
        @(posedge core_clk_i);
        rst_i <= 1'h1;
        repeat (2) @(posedge core_clk_i);
        rst_i <= 1'h0;
        settle;
        chk("dip cleared", 4'h0, {3'h0, dip});
        $display("dip test done");
    endtask : t_dip
    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : conclude
    initial begin
        repeat (12) @(posedge core_clk_i);
        rst_i <= 1'h0;
        t_active;
        t_request;
        t_sleep;
        t_dip;
        conclude;
    end
    initial begin
        #100000;
        fails++;
        conclude;
    end
endmodule : gate_driver_passive_mode_control_test
